// file: rtl/linker_ctl_regs.vh
`ifndef LINKER_CTL_REGS_VH
`define LINKER_CTL_REGS_VH

// control chain layout
`define CTL_WIDTH       10
`define CTL_RESET       10'h000
`define CTL_UPDOWN      9
`define CTL_LATCH_ZERO  8
`define CTL_OUT_POL     7
`define CTL_SRC_HI      6
`define CTL_SRC_LO      5
`define CTL_PAR_MASK    4
`define CTL_DRIVE_TS    3
`define CTL_OUT_EN      2
`define CTL_IN_POL      1
`define CTL_DT_DISABLE  0

// output source codes
`define SRC_STATIC      2'h0
`define SRC_PARITY      2'h1
`define SRC_COUNT_END   2'h2
`define SRC_INPUT       2'h3

// instruction codes
`define IR_WIDTH        8
`define IR_SCANCTL_A    8'h8E
`define IR_SCANCTL_B    8'h0F
`define IR_COUNT_A      8'h88
`define IR_COUNT_B      8'h09

// counter
`define CNT_WIDTH       8
`define CNT_ZERO        8'h00
`define CNT_FULL        8'hFF

// tap states
`define TAP_RESET       4'h0
`define TAP_IDLE        4'h1
`define TAP_SEL_DR      4'h2
`define TAP_CAP_DR      4'h3
`define TAP_SHIFT_DR    4'h4
`define TAP_EXIT1_DR    4'h5
`define TAP_PAUSE_DR    4'h6
`define TAP_EXIT2_DR    4'h7
`define TAP_UPDATE_DR   4'h8
`define TAP_SEL_IR      4'h9
`define TAP_CAP_IR      4'hA
`define TAP_SHIFT_IR    4'hB
`define TAP_EXIT1_IR    4'hC
`define TAP_PAUSE_IR    4'hD
`define TAP_EXIT2_IR    4'hE
`define TAP_UPDATE_IR   4'hF

`endif

// file: rtl/tap_tracker.v
`include "linker_ctl_regs.vh"

// follows the test bus state machine on each sampled test clock rise
module tap_tracker (
	input  wire       sys_clk,
	input  wire       nrst,
	input  wire       tck_rise,
	input  wire       tms,
	output reg  [3:0] tap_state_q
);

	localparam S_RESET    = `TAP_RESET;
	localparam S_IDLE     = `TAP_IDLE;
	localparam S_SEL_DR   = `TAP_SEL_DR;
	localparam S_CAP_DR   = `TAP_CAP_DR;
	localparam S_SHIFT_DR = `TAP_SHIFT_DR;
	localparam S_EXIT1_DR = `TAP_EXIT1_DR;
	localparam S_PAUSE_DR = `TAP_PAUSE_DR;
	localparam S_EXIT2_DR = `TAP_EXIT2_DR;
	localparam S_UPD_DR   = `TAP_UPDATE_DR;
	localparam S_SEL_IR   = `TAP_SEL_IR;
	localparam S_CAP_IR   = `TAP_CAP_IR;
	localparam S_SHIFT_IR = `TAP_SHIFT_IR;
	localparam S_EXIT1_IR = `TAP_EXIT1_IR;
	localparam S_PAUSE_IR = `TAP_PAUSE_IR;
	localparam S_EXIT2_IR = `TAP_EXIT2_IR;
	localparam S_UPD_IR   = `TAP_UPDATE_IR;

	reg [3:0] tap_state_d;

	always @* begin
		case (tap_state_q)
			S_RESET:    tap_state_d = tms ? S_RESET : S_IDLE;
			S_IDLE:     tap_state_d = tms ? S_SEL_DR : S_IDLE;
			S_SEL_DR:   tap_state_d = tms ? S_SEL_IR : S_CAP_DR;
			S_CAP_DR:   tap_state_d = tms ? S_EXIT1_DR : S_SHIFT_DR;
			S_SHIFT_DR: tap_state_d = tms ? S_EXIT1_DR : S_SHIFT_DR;
			S_EXIT1_DR: tap_state_d = tms ? S_UPD_DR : S_PAUSE_DR;
			S_PAUSE_DR: tap_state_d = tms ? S_EXIT2_DR : S_PAUSE_DR;
			S_EXIT2_DR: tap_state_d = tms ? S_UPD_DR : S_SHIFT_DR;
			S_UPD_DR:   tap_state_d = tms ? S_SEL_DR : S_IDLE;
			S_SEL_IR:   tap_state_d = tms ? S_RESET : S_CAP_IR;
			S_CAP_IR:   tap_state_d = tms ? S_EXIT1_IR : S_SHIFT_IR;
			S_SHIFT_IR: tap_state_d = tms ? S_EXIT1_IR : S_SHIFT_IR;
			S_EXIT1_IR: tap_state_d = tms ? S_UPD_IR : S_PAUSE_IR;
			S_PAUSE_IR: tap_state_d = tms ? S_EXIT2_IR : S_PAUSE_IR;
			S_EXIT2_IR: tap_state_d = tms ? S_UPD_IR : S_SHIFT_IR;
			S_UPD_IR:   tap_state_d = tms ? S_SEL_DR : S_IDLE;
			default:    tap_state_d = S_RESET;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!nrst)
			tap_state_q <= S_RESET;
		else if (tck_rise)
			tap_state_q <= tap_state_d;
	end

endmodule

// file: rtl/scan_linker_ctl.v
// Contract
// - ten-bit serial control chain, all bits cleared by test logic reset
// - shifted bits act only after latching at Update-DR
// - bit 9 picks counter direction: 0 up, 1 down; reset is up
// - bit 8 with down count halts counter at zero, ignoring input edges
// - bit 7 sets output polarity; inactive drives the opposite level
// - bits 6:5 pick output source: static, parity error, count end, input
// - count end is low at zero counting down or all ones counting up
// - parity output active from falling edge into Pause-IR to Exit2-IR
// - parity output active in Pause-IR only when parity error is low
// - bit 4 masks parity indication, holding output inactive
// - bit 3 picks drive: 0 open-drain, 1 three-state; reset open-drain
// - bit 2 enables output; disabled floats or shows high when open-drain
// - bit 1 sets input polarity and the counting edge
// - source 11 makes output active exactly while input is active
// - bit 0 floats downstream clock, data and mode pins; data gated by select
// - parity error is 1 for even count of ones in instruction register
// - counter advances on input events only in Run-Test/Idle under count
// - chain reached only by its scan instruction, no capture at Capture-DR
`include "linker_ctl_regs.vh"

module scan_linker_ctl #(
	parameter IR_W  = `IR_WIDTH,
	parameter CNT_W = `CNT_WIDTH,
	parameter NPATH = 4
) (
	input  wire             sys_clk,
	input  wire             nrst,
	input  wire             tck,
	input  wire             tms,
	input  wire             tdi,
	input  wire [IR_W-1:0]  instruction_reg,
	input  wire             condition_input,
	input  wire [NPATH-1:0] select_data_gate,
	output reg              ctl_tdo_q,
	output reg              condition_output_q,
	output reg              condition_output_oe_q,
	output reg              downstream_test_clock_oe_q,
	output reg              downstream_test_mode_select_oe_q,
	output reg  [NPATH-1:0] downstream_test_data_out_oe_q,
	output reg  [CNT_W-1:0] count_value_q,
	output reg  [9:0]       linker_control_chain_q
);

	// every pin input passes two flops before use
	reg [1:0] tck_sync_q;
	reg [1:0] tms_sync_q;
	reg [1:0] tdi_sync_q;
	reg [1:0] cin_sync_q;
	reg       tck_prev_q;
	reg       cin_prev_q;
	reg [9:0] shift_q;
	reg       parity_window_q;
	wire      tck_rise;
	wire      tck_fall;
	wire [3:0] tap_state;

	function is_ctl_scan;
		input [IR_W-1:0] ir;
		begin
			is_ctl_scan = (ir == `IR_SCANCTL_A) || (ir == `IR_SCANCTL_B);
		end
	endfunction

	function is_count;
		input [IR_W-1:0] ir;
		begin
			is_count = (ir == `IR_COUNT_A) || (ir == `IR_COUNT_B);
		end
	endfunction

	always @(posedge sys_clk) begin
		if (!nrst) begin
			tck_sync_q <= 2'h0;
			tms_sync_q <= 2'h3;
			tdi_sync_q <= 2'h3;
			cin_sync_q <= 2'h0;
			tck_prev_q <= 1'b0;
			cin_prev_q <= 1'b0;
		end else begin
			tck_sync_q <= {tck_sync_q[0], tck};
			tms_sync_q <= {tms_sync_q[0], tms};
			tdi_sync_q <= {tdi_sync_q[0], tdi};
			cin_sync_q <= {cin_sync_q[0], condition_input};
			tck_prev_q <= tck_sync_q[1];
			cin_prev_q <= cin_sync_q[1];
		end
	end

	assign tck_rise = tck_sync_q[1] & ~tck_prev_q;
	assign tck_fall = ~tck_sync_q[1] & tck_prev_q;

	tap_tracker u_tap (
		.sys_clk     (sys_clk),
		.nrst        (nrst),
		.tck_rise    (tck_rise),
		.tms         (tms_sync_q[1]),
		.tap_state_q (tap_state)
	);

	wire ctl_sel = is_ctl_scan(instruction_reg);

	// shift on rising edges; Capture-DR leaves the chain untouched
	always @(posedge sys_clk) begin
		if (!nrst)
			shift_q <= `CTL_RESET;
		else if (tap_state == `TAP_RESET)
			shift_q <= `CTL_RESET;
		else if (tck_rise && ctl_sel && tap_state == `TAP_SHIFT_DR)
			shift_q <= {tdi_sync_q[1], shift_q[9:1]};
	end

	// latch on the falling edge inside Update-DR
	always @(posedge sys_clk) begin
		if (!nrst)
			linker_control_chain_q <= `CTL_RESET;
		else if (tap_state == `TAP_RESET)
			linker_control_chain_q <= `CTL_RESET;
		else if (tck_fall && ctl_sel && tap_state == `TAP_UPDATE_DR)
			linker_control_chain_q <= shift_q;
	end

	always @(posedge sys_clk) begin
		if (!nrst)
			ctl_tdo_q <= 1'b0;
		else if (tck_fall)
			ctl_tdo_q <= shift_q[0];
	end

	wire       count_down = linker_control_chain_q[`CTL_UPDOWN];
	wire       latch_zero = linker_control_chain_q[`CTL_LATCH_ZERO];
	wire       out_pol    = linker_control_chain_q[`CTL_OUT_POL];
	wire [1:0] src_sel    = {linker_control_chain_q[`CTL_SRC_HI],
	                         linker_control_chain_q[`CTL_SRC_LO]};
	wire       par_mask   = linker_control_chain_q[`CTL_PAR_MASK];
	wire       drive_ts   = linker_control_chain_q[`CTL_DRIVE_TS];
	wire       out_en     = linker_control_chain_q[`CTL_OUT_EN];
	wire       in_pol     = linker_control_chain_q[`CTL_IN_POL];
	wire       dt_disable = linker_control_chain_q[`CTL_DT_DISABLE];

	// input edge into active level counts as one event
	wire cin_now   = cin_sync_q[1];
	wire cin_event = (cin_now ^ cin_prev_q) & (cin_now == in_pol);
	wire cin_act   = (cin_now == in_pol);

	wire parity_err = ~(^instruction_reg);

	wire count_end_n = count_down ? (count_value_q != `CNT_ZERO)
	                              : (count_value_q != `CNT_FULL);

	wire halt = count_down & latch_zero & (count_value_q == `CNT_ZERO);

	// preload and readback of the counter live elsewhere
	always @(posedge sys_clk) begin
		if (!nrst)
			count_value_q <= `CNT_ZERO;
		else if (cin_event && !halt && is_count(instruction_reg) &&
		         tap_state == `TAP_IDLE) begin
			if (count_down)
				count_value_q <= count_value_q - 1'b1;
			else
				count_value_q <= count_value_q + 1'b1;
		end
	end

	// window tracks the falling edges into Pause-IR and into Exit2-IR
	always @(posedge sys_clk) begin
		if (!nrst)
			parity_window_q <= 1'b0;
		else if (tck_fall)
			parity_window_q <= (tap_state == `TAP_PAUSE_IR);
	end

	reg active;
	reg pin_level;
	reg pin_oe;

	always @* begin
		case (src_sel)
			`SRC_STATIC:    active = 1'b0;
			`SRC_PARITY:    active = parity_window_q & ~parity_err & ~par_mask;
			`SRC_COUNT_END: active = ~count_end_n;
			`SRC_INPUT:     active = cin_act;
			default:        active = 1'b0;
		endcase
		pin_level = active ? out_pol : ~out_pol;
		// open-drain only pulls low; a high level comes from the pull-up
		if (!out_en) begin
			pin_level = 1'b1;
			pin_oe    = 1'b0;
		end else if (drive_ts) begin
			pin_oe    = 1'b1;
		end else begin
			pin_oe    = ~pin_level;
			pin_level = 1'b0;
		end
	end

	always @(posedge sys_clk) begin
		if (!nrst) begin
			condition_output_q    <= 1'b1;
			condition_output_oe_q <= 1'b0;
		end else begin
			condition_output_q    <= pin_level;
			condition_output_oe_q <= pin_oe;
		end
	end

	always @(posedge sys_clk) begin
		if (!nrst) begin
			downstream_test_clock_oe_q       <= 1'b1;
			downstream_test_mode_select_oe_q <= 1'b1;
			downstream_test_data_out_oe_q    <= {NPATH{1'b0}};
		end else begin
			downstream_test_clock_oe_q       <= ~dt_disable;
			downstream_test_mode_select_oe_q <= ~dt_disable;
			downstream_test_data_out_oe_q    <= {NPATH{~dt_disable}} & select_data_gate;
		end
	end

endmodule

// file: tb/linker_ctl_checker.sv
module linker_ctl_checker #(
	parameter IR_W  = 8,
	parameter CNT_W = 8,
	parameter NPATH = 4
) (
	input wire             sys_clk,
	input wire             nrst,
	input wire [IR_W-1:0]  instruction_reg,
	input wire [NPATH-1:0] select_data_gate,
	input wire             condition_output_q,
	input wire             condition_output_oe_q,
	input wire             downstream_test_clock_oe_q,
	input wire             downstream_test_mode_select_oe_q,
	input wire [NPATH-1:0] downstream_test_data_out_oe_q,
	input wire [CNT_W-1:0] count_value_q,
	input wire [9:0]       linker_control_chain_q
);
	wire [9:0] c       = linker_control_chain_q;
	wire       scan_ir = instruction_reg == 8'h8E || instruction_reg == 8'h0F;
	// wired level with the board pull-up
	wire       lvl     = condition_output_oe_q ? condition_output_q : 1'b1;
	reg        ce_q;
	always @(posedge sys_clk) begin
		ce_q <= (c[9] ? count_value_q == 8'h00 : &count_value_q) == c[7];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	rst_clear_a: assert property (disable iff (1'b0) !nrst |=> c == 10'h000
		&& !condition_output_oe_q) else $error("chain or output not cleared");
	// test logic reset may still clear the chain under any instruction
	chain_hold_a: assert property (!scan_ir ##1 !scan_ir |=> $stable(c) || c == 10'h000)
		else $error("chain moved without its instruction");
	off_drive_a: assert property (!c[2] |=> !condition_output_oe_q && condition_output_q)
		else $error("disabled output still driving");
	od_value_a: assert property (c[2] && !c[3] |=> !condition_output_q)
		else $error("open drain drove high");
	ts_enable_a: assert property (c[2] && c[3] |=> condition_output_oe_q)
		else $error("three-state output not driving");
	static_lvl_a: assert property (c[2] && c[6:5] == 2'h0 |=> lvl == !$past(c[7]))
		else $error("static source not inactive");
	parity_mask_a: assert property (c[2] && c[6:5] == 2'h1 && c[4] |=> lvl == !$past(c[7]))
		else $error("masked parity reached output");
	count_end_a: assert property (c[2] && c[6:5] == 2'h2 |=> lvl == ce_q)
		else $error("count end level wrong");
	zero_halt_a: assert property (c[9] && c[8] && count_value_q == 8'h00 |=> count_value_q == 8'h00)
		else $error("counter left zero while latched");
	dt_enable_a: assert property (nrst |=> downstream_test_clock_oe_q == !$past(c[0])
		&& downstream_test_mode_select_oe_q == !$past(c[0]) && downstream_test_data_out_oe_q
		== ($past(select_data_gate) & {NPATH{!$past(c[0])}})) else $error("test pin enables wrong");
	cover property (c[2] && c[6:5] == 2'h1 && condition_output_oe_q && !condition_output_q);
	cover property (c[9] && c[8] && count_value_q == 8'h00);
	cover property (c[2] && c[6:5] == 2'h3);
endmodule

bind scan_linker_ctl linker_ctl_checker #(.IR_W(IR_W), .CNT_W(CNT_W), .NPATH(NPATH))
	linker_ctl_checker_inst (.sys_clk(sys_clk), .nrst(nrst),
	.instruction_reg(instruction_reg), .select_data_gate(select_data_gate),
	.condition_output_q(condition_output_q), .condition_output_oe_q(condition_output_oe_q),
	.downstream_test_clock_oe_q(downstream_test_clock_oe_q),
	.downstream_test_mode_select_oe_q(downstream_test_mode_select_oe_q),
	.downstream_test_data_out_oe_q(downstream_test_data_out_oe_q),
	.count_value_q(count_value_q), .linker_control_chain_q(linker_control_chain_q));

// file: tb/tap_master.sv
module tap_master (
	output logic tck,
	output logic tms,
	output logic tdi
);
	timeunit 1ns;
	timeprecision 1ps;
	// test clock stands low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// nonblocking, so a change that lands on a system clock edge is never raced
	task automatic step(input logic m, input logic d);
		tms <= m;
		tdi <= d;
		#32 tck <= 1'b1;
		#32 tck <= 1'b0;
	endtask
	// tms bits go out lsb first; idle data line toggles so it never looks held
	task automatic walk(input logic [7:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			step(bits[i], ~tdi);
		end
	endtask
	task automatic load(input logic [9:0] v);
		walk(8'h01, 3);
		for (int i = 0; i < 10; i++) begin
			step(i == 9, v[i]);
		end
		walk(8'h01, 2);
	endtask
endmodule

// file: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk = 1'b0;
	logic       nrst = 1'b0;
	logic [7:0] ir = 8'h8E;
	logic       cin = 1'b1;
	logic [3:0] gate = 4'hA;
	wire        tck, tms, tdi, tdo, cq, coe, clk_oe, ms_oe;
	wire  [3:0] do_oe;
	wire  [7:0] cnt;
	wire  [9:0] ctl;
	// pull-up on the shared condition line
	wire        pin = coe ? cq : 1'b1;
	int         error_cnt = 0;
	int         checks_done = 0;
	int         cyc = 0;
	localparam logic [9:0] cfg_tab [7] = '{10'h000, 10'h004, 10'h084, 10'h08C, 10'h00C,
		10'h008, 10'h001};
	localparam logic [1:0] pin_tab [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1, 2'h1};
	scan_linker_ctl scan_linker_ctl_inst (.sys_clk(sys_clk), .nrst(nrst), .tck(tck),
		.tms(tms), .tdi(tdi), .instruction_reg(ir), .condition_input(cin),
		.select_data_gate(gate), .ctl_tdo_q(tdo), .condition_output_q(cq),
		.condition_output_oe_q(coe), .downstream_test_clock_oe_q(clk_oe),
		.downstream_test_mode_select_oe_q(ms_oe), .downstream_test_data_out_oe_q(do_oe),
		.count_value_q(cnt), .linker_control_chain_q(ctl));
	tap_master tap_master_inst (.tck(tck), .tms(tms), .tdi(tdi));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic set_ir(input logic [7:0] v);
		@(posedge sys_clk);
		ir <= v;
	endtask
	task automatic load(input logic [9:0] v);
		set_ir(8'h8E);
		tap_master_inst.load(v);
		wt(10);
	endtask
	task automatic drive(input logic v);
		@(posedge sys_clk);
		cin <= v;
		wt(8);
	endtask
	task automatic t_reset();
		chk(ctl, 10'h000);
		chk(cnt, 8'h00);
		chk({clk_oe, ms_oe, do_oe, coe, pin}, 8'hE9);
	endtask
	task automatic t_decode();
		for (int i = 0; i < 7; i++) begin
			load(cfg_tab[i]);
			chk(ctl, cfg_tab[i]);
			chk({coe, pin}, pin_tab[i]);
			chk({clk_oe, ms_oe, do_oe}, cfg_tab[i][0] ? 6'h00 : 6'h3A);
		end
	endtask
	task automatic t_mirror();
		load(10'h0EE);
		drive(1'b1);
		chk({coe, pin}, 2'h3);
		drive(1'b0);
		chk({coe, pin}, 2'h2);
		load(10'h06C);
		chk({coe, pin}, 2'h2);
		drive(1'b1);
		chk({coe, pin}, 2'h3);
	endtask
	task automatic pause_chk(input logic [7:0] v, input logic [1:0] e);
		set_ir(v);
		tap_master_inst.walk(8'h13, 6);
		wt(8);
		chk({coe, pin}, e);
		tap_master_inst.walk(8'h01, 1);
		wt(8);
		chk({coe, pin}, 2'h3);
		tap_master_inst.walk(8'h01, 2);
	endtask
	task automatic t_parity();
		load(10'h02C);
		pause_chk(8'h07, 2'h2);
		pause_chk(8'h8E, 2'h3);
		load(10'h03C);
		pause_chk(8'h07, 2'h3);
	endtask
	task automatic t_readback();
		logic [9:0] got;
		logic [9:0] nxt;
		got = 10'h000;
		nxt = 10'h14A;
		load(10'h2B5);
		set_ir(8'h8E);
		tap_master_inst.walk(8'h01, 3);
		for (int i = 0; i < 10; i++) begin
			wt(6);
			got[i] = tdo;
			tap_master_inst.step(i == 9, nxt[i]);
		end
		wt(6);
		chk(ctl, 10'h2B5);
		chk(got, 10'h2B5);
		tap_master_inst.walk(8'h01, 2);
		wt(10);
		chk(ctl, 10'h14A);
		set_ir(8'h07);
		tap_master_inst.load(10'h3FF);
		wt(10);
		chk(ctl, 10'h14A);
		set_ir(8'h8E);
		tap_master_inst.walk(8'h1F, 6);
		wt(8);
		chk(ctl, 10'h000);
	endtask
	task automatic t_count();
		load(10'h002);
		set_ir(8'h88);
		drive(1'b0);
		chk(cnt, 8'h00);
		repeat (2) begin
			drive(1'b1);
			drive(1'b0);
		end
		chk(cnt, 8'h02);
		tap_master_inst.walk(8'h05, 4);
		drive(1'b1);
		chk(cnt, 8'h02);
		tap_master_inst.walk(8'h03, 3);
		load(10'h344);
		set_ir(8'h88);
		drive(1'b0);
		chk({coe, pin}, 2'h1);
		repeat (2) begin
			drive(1'b1);
			drive(1'b0);
		end
		chk(cnt, 8'h00);
		chk({coe, pin}, 2'h2);
	endtask
	initial begin
		wt(6);
		nrst <= 1'b1;
		wt(4);
		tap_master_inst.walk(8'h1F, 6);
		wt(6);
		t_reset();
		t_decode();
		t_mirror();
		t_parity();
		t_readback();
		t_count();
		report_and_stop();
	end
endmodule
